// ==== bsf_pkg.sv ====
// package: register map, field positions, reset values and counts for the buffered spi block
package bsf_pkg;
  localparam logic [4:0] BSF_OFF_RX = 5'h00;
  localparam logic [4:0] BSF_OFF_TX = 5'h04;
  localparam logic [4:0] BSF_OFF_CSR1 = 5'h08;
  localparam logic [4:0] BSF_OFF_CSR2 = 5'h0c;
  localparam logic [4:0] BSF_OFF_CLK = 5'h10;
  localparam logic [15:0] BSF_RST_CSR1 = 16'h0000;
  localparam logic [15:0] BSF_RST_CSR2 = 16'h0040;
  localparam logic [15:0] BSF_RST_CLK = 16'h0006;
  localparam logic [15:0] BSF_RST_RX = 16'h0000;
  localparam int BSF_FIFO_WORDS = 10;
  localparam logic [3:0] BSF_DEPTH_MAX_CODE = 4'h9;
  localparam logic [1:0] BSF_IRQ_OFF = 2'h0;
  localparam logic [1:0] BSF_IRQ_EMPTY = 2'h1;
  localparam logic [1:0] BSF_IRQ_UFL = 2'h2;
  localparam logic [1:0] BSF_IRQ_FULL = 2'h3;
  localparam logic [1:0] BSF_WLEN_8 = 2'h0;
  localparam logic [1:0] BSF_WLEN_16 = 2'h1;
  localparam logic [4:0] BSF_BITS_8 = 5'h08;
  localparam logic [4:0] BSF_BITS_16 = 5'h10;
  // csr1 fields
  localparam int BSF_C1_RXDEP = 12;
  localparam int BSF_C1_WLEN = 10;
  localparam int BSF_C1_PHASE = 9;
  localparam int BSF_C1_POLAR = 8;
  localparam int BSF_C1_BEIE = 7;
  localparam int BSF_C1_RXERR = 4;
  localparam int BSF_C1_RXIRQ = 2;
  localparam int BSF_C1_MASTER = 1;
  localparam int BSF_C1_EN = 0;
  // csr2 fields
  localparam int BSF_C2_TXIRQ = 14;
  localparam int BSF_C2_TXDEP = 10;
  localparam int BSF_C2_FLUSH = 0;
endpackage

// ==== bsf_fifo.sv ====
// file: word fifo with selectable depth and flush
`timescale 1ns/1ns
module bsf_fifo import bsf_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int WORDS = BSF_FIFO_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic [3:0] depth_code_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic [3:0] count_o,
  output logic full_o
);
  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
    logic [3:0] rd;
    logic [3:0] wr;
    logic [3:0] cnt;
  } bsf_fifo_st_t;
  bsf_fifo_st_t st;
  bsf_fifo_st_t next_st;
  logic [3:0] limit;
  logic do_push;
  logic do_pop;

  function automatic logic [3:0] bsf_depth(input logic [3:0] code);
    bsf_depth = (code <= BSF_DEPTH_MAX_CODE) ? code + 4'h1 : 4'h1;
  endfunction

  function automatic logic [3:0] bsf_wrap(input logic [3:0] p, input logic [3:0] lim);
    bsf_wrap = (p + 4'h1 >= lim) ? 4'h0 : p + 4'h1;
  endfunction

  always_comb begin
    next_st = st;
    limit = bsf_depth(depth_code_i);
    do_pop = pop_i && st.cnt != 4'h0;
    do_push = push_i && (st.cnt < limit || do_pop);
    if (do_push) begin
      next_st.mem[st.wr] = push_data_i;
      next_st.wr = bsf_wrap(st.wr, limit);
    end
    if (do_pop) begin
      next_st.rd = bsf_wrap(st.rd, limit);
    end
    next_st.cnt = st.cnt + (do_push ? 4'h1 : 4'h0) - (do_pop ? 4'h1 : 4'h0);
    if (flush_i) begin
      next_st.rd = 4'h0;
      next_st.wr = 4'h0;
      next_st.cnt = 4'h0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head_o = st.mem[st.rd];
  assign count_o = st.cnt;
  assign full_o = st.cnt >= bsf_depth(depth_code_i);
endmodule // bsf_fifo

// ==== bsf_spi.sv ====
// file: buffered spi with fifos, status flags and master clock divider
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module bsf_spi import bsf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic irq_o
);
  typedef struct packed {
    logic [15:0] csr1;
    logic [1:0] tie;
    logic [3:0] tx_depth_select;
    logic flush;
    logic [7:0] div;
    logic tx_empty;
    logic tx_ufl;
    logic rx_ofl;
    logic ofl_seen;
    logic contention;
    logic [15:0] rdata;
    logic [15:0] shift;
    logic [4:0] bits;
    logic busy;
    logic [7:0] dcnt;
    logic sclk;
    logic sclk_d;
    logic ss_d;
    logic edge_odd;
    logic [15:0] direct_tx;
    logic direct_full;
    logic rx_held;
    logic out_bit;
  } bsf_st_t;
  bsf_st_t st;
  bsf_st_t next_st;

  logic enabled;
  logic master;
  logic phase;
  logic polarity;
  logic [4:0] word_bits;
  logic tx_fifo_on;
  logic rx_fifo_on;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic [15:0] tx_head;
  logic [15:0] rx_head;
  logic [3:0] tx_cnt;
  logic [3:0] rx_cnt;
  logic tx_full;
  logic rx_full;
  logic tx_avail;
  logic [15:0] rx_word;
  logic bit_edge;
  logic lead_edge;
  logic sample_edge;
  logic frame_start;
  logic wr_tx;
  logic rd_rx;
  logic rd_csr2;
  logic [15:0] csr2_view;
  logic [3:0] rx_depth_code;
  logic drive_edge;
  logic sin;
  logic rx_done;
  logic rx_ne;
  logic rx_fl;

  function automatic logic [15:0] bsf_justify(input logic [15:0] w, input logic [4:0] n);
    bsf_justify = (n == BSF_BITS_8) ? {w[7:0], 8'h00} : w;
  endfunction

  assign enabled = st.csr1[BSF_C1_EN];
  assign master = st.csr1[BSF_C1_MASTER];
  assign phase = st.csr1[BSF_C1_PHASE];
  assign polarity = st.csr1[BSF_C1_POLAR];
  assign rx_depth_code = st.csr1[BSF_C1_RXDEP +: 4];
  assign word_bits = (st.csr1[BSF_C1_WLEN +: 2] == BSF_WLEN_8) ? BSF_BITS_8 : BSF_BITS_16;
  assign tx_fifo_on = st.tx_depth_select != 4'h0 && st.tx_depth_select <= BSF_DEPTH_MAX_CODE;
  assign rx_fifo_on = rx_depth_code != 4'h0 && rx_depth_code <= BSF_DEPTH_MAX_CODE;
  assign wr_tx = wr_i && addr_i == BSF_OFF_TX;
  assign rd_rx = rd_i && addr_i == BSF_OFF_RX;
  assign rd_csr2 = rd_i && addr_i == BSF_OFF_CSR2;

  // ------------------------------------------------------------
  // serial timing
  // ------------------------------------------------------------
  // master: edge when divider half period elapses; slave: sclk_i toggles
  assign bit_edge = st.busy && (master ? (st.dcnt == 8'h01)
                                       : (sclk_i != st.sclk_d));
  assign lead_edge = bit_edge && !st.edge_odd;
  assign sample_edge = bit_edge && (phase ? st.edge_odd : !st.edge_odd);
  // data line only moves on the edge that does not sample
  assign drive_edge = bit_edge && !sample_edge;
  // frame start: master pulls ss low itself, slave sees ss fall
  assign frame_start = enabled && !st.busy &&
                       (master ? (tx_avail || st.tx_empty == 1'b0)
                               : (st.ss_d && !ss_n_i));
  assign tx_avail = tx_fifo_on ? (tx_cnt != 4'h0) : st.direct_full;
  assign tx_pop = frame_start && tx_fifo_on && tx_cnt != 4'h0;
  assign tx_push = wr_tx && tx_fifo_on;
  assign sin = master ? miso_i : mosi_i;
  // phase 0 ends on the edge after the last sample, so sclk returns to idle
  assign rx_done = phase ? (sample_edge && st.bits == 5'h01)
                         : (drive_edge && st.bits == 5'h00);
  assign rx_word = bsf_justify(phase ? {st.shift[14:0], sin} : st.shift, word_bits);
  assign rx_push = rx_fifo_on && rx_done;
  assign rx_pop = rd_rx && rx_fifo_on;
  assign rx_ne = rx_fifo_on ? rx_cnt != 4'h0 : st.rx_held;
  assign rx_fl = rx_fifo_on ? rx_full : st.rx_held;

  bsf_fifo #(.WIDTH(16), .WORDS(BSF_FIFO_WORDS)) u_tx_fifo (
    .clk_i(clk_i), .rst_i(rst_i), .flush_i(st.flush),
    .depth_code_i(st.tx_depth_select), .push_i(tx_push), .push_data_i(wdata_i),
    .pop_i(tx_pop), .head_o(tx_head), .count_o(tx_cnt), .full_o(tx_full)
  );
  bsf_fifo #(.WIDTH(16), .WORDS(BSF_FIFO_WORDS)) u_rx_fifo (
    .clk_i(clk_i), .rst_i(rst_i), .flush_i(st.flush),
    .depth_code_i(rx_depth_code), .push_i(rx_push), .push_data_i(rx_word),
    .pop_i(rx_pop), .head_o(rx_head), .count_o(rx_cnt), .full_o(rx_full)
  );

  assign csr2_view = {st.tie, st.tx_depth_select,
                      tx_cnt != 4'h0 || st.direct_full,
                      tx_fifo_on ? tx_full : st.direct_full,
                      st.tx_ufl, st.tx_empty, st.rx_ofl,
                      rx_fl, rx_ne, st.contention, 1'b0, 1'b0};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.flush = 1'b0;
    next_st.sclk_d = sclk_i;
    next_st.ss_d = ss_n_i;
    if (wr_i) begin
      unique case (addr_i)
        BSF_OFF_CSR1: next_st.csr1 = wdata_i & 16'hff9f;
        BSF_OFF_CSR2: begin
          next_st.tie = wdata_i[BSF_C2_TXIRQ +: 2];
          next_st.tx_depth_select = wdata_i[BSF_C2_TXDEP +: 4];
          next_st.flush = wdata_i[BSF_C2_FLUSH];
        end
        BSF_OFF_CLK: next_st.div = wdata_i[7:0];
        BSF_OFF_TX: begin
          if (!tx_fifo_on) begin
            next_st.direct_tx = wdata_i;
            next_st.direct_full = 1'b1;
          end
          next_st.tx_empty = 1'b0;
          next_st.tx_ufl = 1'b0;
        end
        default: ;
      endcase
    end
    // flush also drops the word waiting on the direct path
    if (st.flush) begin
      next_st.csr1[BSF_C1_RXDEP +: 4] = 4'h0;
      next_st.direct_full = 1'b0;
      next_st.tx_empty = 1'b1;
    end
    // overflow clears after status read followed by data read
    if (rd_csr2 && st.rx_ofl) begin
      next_st.ofl_seen = 1'b1;
    end
    if (rd_rx && st.ofl_seen) begin
      next_st.rx_ofl = 1'b0;
      next_st.ofl_seen = 1'b0;
    end
    if (rd_rx && !rx_fifo_on) begin
      next_st.rx_held = 1'b0;
    end else if (rd_rx) begin
      next_st.rdata = rx_head;
    end
    // ---- frame start: load shift register
    if (frame_start) begin
      next_st.busy = 1'b1;
      next_st.bits = word_bits;
      next_st.dcnt = st.div >> 1;
      next_st.sclk = polarity;
      next_st.edge_odd = 1'b0;
      if (tx_avail) begin
        next_st.shift = tx_fifo_on ? tx_head : st.direct_tx;
        next_st.out_bit = tx_fifo_on ? tx_head[15] : st.direct_tx[15];
        next_st.direct_full = 1'b0;
        next_st.tx_empty = tx_fifo_on ? (tx_cnt == 4'h1) : 1'b1;
      end else if (!phase) begin
        next_st.tx_ufl = 1'b1;
      end
    end
    if (st.busy) begin
      next_st.dcnt = (st.dcnt <= 8'h01) ? (st.div >> 1) : st.dcnt - 8'h01;
      if (bit_edge) begin
        next_st.edge_odd = !st.edge_odd;
        next_st.sclk = !st.sclk;
      end
      if (lead_edge && phase && st.bits == word_bits && st.tx_empty && !tx_avail) begin
        next_st.tx_ufl = 1'b1;
      end
      if (sample_edge) begin
        next_st.shift = {st.shift[14:0], sin};
        next_st.bits = st.bits - 5'h01;
      end
      if (drive_edge) begin
        next_st.out_bit = st.shift[15];
      end
      if (rx_done) begin
        next_st.busy = 1'b0;
        if (rx_fifo_on ? rx_full && !rx_pop : st.rx_held && !rd_rx) begin
          next_st.rx_ofl = 1'b1;
        end
        if (!rx_fifo_on) begin
          next_st.rdata = rx_word;
          next_st.rx_held = 1'b1;
        end
      end
    end
    if (!enabled) begin
      next_st.busy = 1'b0;
      next_st.bits = 5'h00;
      next_st.sclk = polarity;
    end
    if (enabled && master && !ss_n_i) begin
      next_st.contention = 1'b1;
    end else if (!master) begin
      next_st.contention = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.csr1 <= BSF_RST_CSR1;
      st.div <= BSF_RST_CLK[7:0];
      st.tx_empty <= BSF_RST_CSR2[6];
      st.rdata <= BSF_RST_RX;
      st.ss_d <= 1'b1;
      st.sclk_d <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // register reads and outputs
  // ------------------------------------------------------------
  logic [15:0] next_rdata_o;
  always_comb begin
    next_rdata_o = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        BSF_OFF_RX: next_rdata_o = rx_fifo_on ? rx_head : st.rdata;
        BSF_OFF_CSR1: next_rdata_o = st.csr1;
        BSF_OFF_CSR2: next_rdata_o = csr2_view;
        BSF_OFF_CLK: next_rdata_o = {8'h00, st.div};
        default: next_rdata_o = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata_o;
    end
  end

  assign sclk_o = st.sclk;
  assign sclk_oe_n_o = !(enabled && master);
  assign mosi_o = st.out_bit;
  assign mosi_oe_n_o = !(enabled && master);
  assign miso_o = st.out_bit;
  assign miso_oe_n_o = !(enabled && !master && !ss_n_i);
  assign ss_n_o = !(enabled && master && st.busy);

  always_comb begin
    irq_o = 1'b0;
    unique case (st.tie)
      BSF_IRQ_OFF: irq_o = 1'b0;
      BSF_IRQ_EMPTY: irq_o = st.tx_empty;
      BSF_IRQ_UFL: irq_o = st.tx_ufl;
      BSF_IRQ_FULL: irq_o = csr2_view[8];
    endcase
    if (st.csr1[BSF_C1_RXERR] && st.rx_ofl) irq_o = 1'b1;
    if (st.csr1[BSF_C1_RXIRQ +: 2] == BSF_IRQ_EMPTY && rx_ne) irq_o = 1'b1;
    if (st.csr1[BSF_C1_RXIRQ +: 2] == BSF_IRQ_FULL && rx_fl) irq_o = 1'b1;
    if (st.csr1[BSF_C1_BEIE] && st.contention) irq_o = 1'b1;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_flush_self_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    st.flush |=> !st.flush && st.csr1[15:12] == 4'h0)
    else $error("flush did not self clear");
  a_ufl_irq_path: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.tie == BSF_IRQ_UFL && st.tx_ufl) |-> irq_o)
    else $error("underflow irq missing");
  a_tx_not_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_cnt != 4'h0) |-> csr2_view[9])
    else $error("tx not-empty flag low");
  a_contention_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && master && !ss_n_i) |=> st.contention)
    else $error("bus contention not flagged");
  a_tx_empty_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_tx && !frame_start) |=> !st.tx_empty)
    else $error("tx empty not cleared by write");
  a_rx_direct_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_done && !rx_fifo_on && !wr_i) |=> csr2_view[3] && csr2_view[4])
    else $error("direct rx word not flagged");
  a_div_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> st.div == 8'h06)
    else $error("divider reset value wrong");
  a_ofl_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_rx && st.ofl_seen && !rx_done) |=> !st.rx_ofl)
    else $error("overflow not cleared");
endmodule // bsf_spi

// ==== bsf_remote.sv ====
// remote spi slave model on the serial side of the buffered spi block
`timescale 1ns/1ns
module bsf_remote (
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic [15:0] reply_i,
  output logic miso_o,
  output logic [15:0] got_o
);
  logic [15:0] shift;
  logic last;
  initial begin
    shift = 16'h0000;
    got_o = 16'h0000;
    last = 1'b0;
    miso_o = 1'b1;
  end
  // ----------------------------------------
  // mode 0: present on select, sample rising, shift falling
  // ----------------------------------------
  always @(negedge ss_n_i) begin
    shift = reply_i;
    miso_o = reply_i[15];
    last = reply_i[15];
  end
  always @(posedge sclk_i) begin
    if (!ss_n_i) begin
      got_o = {got_o[14:0], mosi_i};
    end
  end
  always @(negedge sclk_i) begin
    if (!ss_n_i) begin
      shift = {shift[14:0], 1'b0};
      miso_o = shift[15];
      last = shift[15];
    end
  end
  // released line must not hold a stale bit
  always @(posedge ss_n_i) begin
    miso_o = ~last;
  end
endmodule // bsf_remote

// ==== buffered_spi_fifo_control_test.sv ====
// self-checking bench for the buffered spi block
`timescale 1ns/1ns
module buffered_spi_fifo_control_test import bsf_pkg::*; ;
  logic clk_i, rst_i, wr_i, rd_i, ss_drv, mosi_idle, rd_seen;
  logic [4:0] addr_i;
  logic [15:0] wdata_i, rdata_o, reply, got, d;
  logic sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, ss_n_o, irq_o, rem_miso;
  wire logic sclk_w, mosi_w, miso_w;
  integer seed = 48, n_fail = 0, compares = 0, n, k, i, t, w, words, div;
  logic [3:0] codes [6];
  logic [15:0] exp_q [$];
  logic [15:0] msk_q [$];
  // sclk pin pulled low when nobody drives it
  assign sclk_w = sclk_oe_n_o ? 1'b0 : sclk_o;
  assign mosi_w = mosi_oe_n_o ? mosi_idle : mosi_o;
  assign miso_w = miso_oe_n_o ? rem_miso : miso_o;
  bsf_spi dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_drv), .ss_n_o(ss_n_o), .irq_o(irq_o));
  bsf_remote rem_u (.sclk_i(sclk_w), .ss_n_i(ss_n_o), .mosi_i(mosi_w), .reply_i(reply),
    .miso_o(rem_miso), .got_o(got));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g,
    input logic [15:0] m);
    compares++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task ck_irq(input logic e);
    @(negedge clk_i);
    chk("irq_o", {15'h0000, e}, {15'h0000, irq_o}, 16'h0001);
  endtask
  task wait_irq;
    k = 0;
    while (irq_o !== 1'b1 && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    chk("irq_o", 16'h0001, {15'h0000, irq_o}, 16'h0001);
    if (k == 100) begin
      give_verdict;
    end
  endtask
  task until_ss(input logic lv);
    n = 0;
    while (ss_n_o !== lv && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 2000) begin
      chk("ss_n_o", {15'h0000, lv}, {15'h0000, ss_n_o}, 16'h0001);
      give_verdict;
    end
  endtask
  task xfer(input logic [1:0] wlen, input logic [15:0] txd);
    d = $random(seed);
    reply = d;
    wr(BSF_OFF_TX, txd);
    until_ss(1'b0);
    chk("mosi_oe_n_o", 16'h0000, {15'h0000, mosi_oe_n_o}, 16'h0001);
    chk("sclk_oe_n_o", 16'h0000, {15'h0000, sclk_oe_n_o}, 16'h0001);
    k = 0;
    while (sclk_o !== 1'b1 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    k = 0;
    while (sclk_o === 1'b1 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    chk("sclk_o high", div[15:0] / 16'h0002, k[15:0], 16'hffff);
    until_ss(1'b1);
    if (wlen == BSF_WLEN_8) begin
      chk("remote word", {8'h00, txd[15:8]}, got, 16'h00ff);
    end else begin
      chk("remote word", txd, got, 16'hffff);
    end
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_seen) begin
      chk("rdata_o", exp_q.pop_front(), rdata_o, msk_q.pop_front());
    end
    rd_seen <= rd_i;
    mosi_idle <= ~mosi_idle;
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    addr_i = 5'h00;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ss_drv = 1'b1;
    mosi_idle = 1'b0;
    rd_seen = 1'b0;
    reply = 16'h0000;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(BSF_OFF_CSR2, BSF_RST_CSR2, 16'hffff);
    rd(BSF_OFF_CLK, BSF_RST_CLK, 16'hffff);
    rd(BSF_OFF_CSR1, BSF_RST_CSR1, 16'hffff);
    rd(BSF_OFF_RX, BSF_RST_RX, 16'hffff);
    rd(5'h14, 16'h0000, 16'hffff);
    ck_irq(1'b0);
    wr(BSF_OFF_CSR2, {BSF_IRQ_EMPTY, 14'h0000});
    ck_irq(1'b1);
    d = $random(seed);
    codes = '{4'h0, 4'h3, 4'h9, 4'ha, 4'hf, d[3:0]};
    foreach (codes[c]) begin
      words = (codes[c] <= BSF_DEPTH_MAX_CODE) ? codes[c] + 1 : 1;
      wr(BSF_OFF_CSR2, {2'b00, codes[c], 10'h001});
      for (i = 0; i < words; i++) begin
        d = $random(seed);
        wr(BSF_OFF_TX, d);
        rd(BSF_OFF_CSR2, {6'h00, 1'b1, i == words - 1, 8'h00}, 16'h0340);
      end
      for (t = 0; t < 4; t++) begin
        wr(BSF_OFF_CSR2, {t[1:0], codes[c], 10'h000});
        ck_irq(t == 3);
      end
    end
    wr(BSF_OFF_CSR1, 16'h5000);
    rd(BSF_OFF_CSR1, 16'h5000, 16'hffff);
    wr(BSF_OFF_CSR2, 16'h0001);
    rd(BSF_OFF_CSR1, 16'h0000, 16'hf000);
    rd(BSF_OFF_CSR2, 16'h0000, 16'h0301);
    div = 6;
    wr(BSF_OFF_CLK, div[15:0]);
    for (w = 0; w < 2; w++) begin
      wr(BSF_OFF_CSR1, {4'h0, w[1:0], 10'h013});
      d = $random(seed);
      xfer(w[1:0], d);
      rd(BSF_OFF_CSR2, 16'h0048, 16'h0048);
      rd(BSF_OFF_RX, reply, (w == 1) ? 16'hffff : 16'hff00);
    end
    xfer(BSF_WLEN_16, d);
    xfer(BSF_WLEN_16, d);
    wait_irq;
    rd(BSF_OFF_CSR2, 16'h0030, 16'h0030);
    rd(BSF_OFF_RX, 16'h0000, 16'h0000);
    rd(BSF_OFF_CSR2, 16'h0000, 16'h0038);
    ck_irq(1'b0);
    wr(BSF_OFF_CSR1, 16'h0483);
    ss_drv <= 1'b0;
    wait_irq;
    rd(BSF_OFF_CSR2, 16'h0004, 16'h0004);
    ss_drv <= 1'b1;
    wr(BSF_OFF_CSR1, 16'h0000);
    wr(BSF_OFF_CLK, 16'h0008);
    wr(BSF_OFF_CSR1, 16'h0401);
    wr(BSF_OFF_CSR2, {BSF_IRQ_UFL, 14'h0000});
    ck_irq(1'b0);
    rd(BSF_OFF_CSR2, 16'h0040, 16'h00c4);
    ss_drv <= 1'b0;
    wait_irq;
    chk("miso_oe_n_o", 16'h0000, {15'h0000, miso_oe_n_o}, 16'h0001);
    chk("sclk_oe_n_o", 16'h0001, {15'h0000, sclk_oe_n_o}, 16'h0001);
    rd(BSF_OFF_CSR2, 16'h00c0, 16'h00c0);
    d = $random(seed);
    wr(BSF_OFF_TX, d);
    rd(BSF_OFF_CSR2, 16'h0000, 16'h0080);
    ck_irq(1'b0);
    rd(BSF_OFF_RX, 16'h0000, 16'h0000);
    ss_drv <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("pending reads", 16'h0000, exp_q.size(), 16'hffff);
    give_verdict;
  end
endmodule // buffered_spi_fifo_control_test
